//--- rtl/system_reset_power_mode_control.sv
// reset sequencing, power mode control and clock gating of the chip
// assumes all inputs synchronous to i_ref_clk; i_sys_rst is power-up
//
// Overview of operation
// RULE1: stretch resets by three 32-clock phases; power-on reset holds 2^21.
// RULE2: power-on detector or reset pin resets core and all peripherals.
// RULE3: watchdog or software reset keeps the boot select bits unchanged.
// RULE4: debug mode: watchdog off, pwm optionally off, others keep running.
// RULE5: wait mode stops core and memory clocks, enabled peripherals run.
// RULE6: wait mode optionally stops watchdog and forces pwm outputs off.
// RULE7: stop mode shuts core, memory and most peripheral clocks.
// RULE8: stop mode optionally stops the watchdog and the can controller.
// RULE9: software itself shuts the pll before stop; no automatic shutdown.
// RULE10: can or ungated interrupt activity wakes the chip from stop.
// RULE11: separate controls disable the effect of wait and stop instructions.
// RULE12: four 16-bit scratch registers cleared only by power-on reset.
// RULE13: flash security blocks external debug access to on-chip flash.
// RULE14: each peripheral clock can be gated individually.
// RULE15: mode word resets to zero except boot bits, set by flash security.
// RULE16: run mode clocks core and all enabled peripherals fully.
// RULE17: a reset source during the release count restarts it from zero.
// RULE18: release peripherals before the core across the three phases.
`timescale 1ns/1ns
`include "sys_glue_regs.svh"

module system_reset_power_mode_control #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int PERIPHS    = `PERIPH_COUNT
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_por,
  input  wire logic                      i_reset_pin_n,
  input  wire logic                      i_watchdog_reset,
  input  wire logic                      i_sw_reset,
  input  wire logic                      i_flash_secure,
  input  wire logic                      i_wait_instr,
  input  wire logic                      i_stop_instr,
  input  wire logic                      i_wait_disable,
  input  wire logic                      i_stop_disable,
  input  wire logic                      i_debug_req,
  input  wire logic                      i_debug_pwm_off,
  input  wire logic                      i_wait_watchdog_stop,
  input  wire logic                      i_wait_pwm_off,
  input  wire logic                      i_stop_watchdog_stop,
  input  wire logic                      i_stop_can_stop,
  input  wire logic                      i_can_wake,
  input  wire logic                      i_irq_wake,
  input  wire logic [PERIPHS-1:0]        i_periph_clk_en,
  input  wire logic                      i_mode_word_wr,
  input  wire logic [15:0]               i_mode_word_wdata,
  input  wire logic                      i_scratch_wr,
  input  wire logic [1:0]                i_scratch_sel,
  input  wire logic [15:0]               i_scratch_wdata,
  input  wire logic                      i_jtag_flash_req,
  output logic                           o_core_rst,
  output logic                           o_periph_rst,
  output sys_glue_pkg::clk_gate_t        o_clk_gate,
  output sys_glue_pkg::power_state_t     o_power_state,
  output logic [15:0]                    o_core_mode_word,
  output logic [15:0]                    o_scratch_rdata,
  output logic                           o_jtag_flash_grant
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [21:0] release_target(input logic long_len);
    if (long_len) begin
      release_target = 22'(POR_CYCLES);
    end else begin
      release_target = 22'(`PHASE_CYCLES * `PHASE_COUNT);
    end
  endfunction

  logic        reset_src;
  logic        hard_src;
  logic [21:0] rst_cnt_q;
  logic        busy_q;
  logic        long_q;
  logic        hard_q;
  logic [21:0] target;
  logic        seq_done;

  sys_glue_pkg::power_state_t state_q;
  sys_glue_pkg::power_state_t state_d;
  sys_glue_pkg::clk_gate_t    gate_d;

  logic [15:0] scratch_q [4];
  logic [15:0] mode_word_q;

  assign hard_src  = i_por | ~i_reset_pin_n;                          // RULE2
  assign reset_src = hard_src | i_watchdog_reset | i_sw_reset;
  assign target    = release_target(long_q);
  assign seq_done  = busy_q & (rst_cnt_q == target - 22'h000001);

  // ***************************************************************
  // reset stretch counter
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_cnt_q <= 22'h000000;
      busy_q    <= 1'b1;
      long_q    <= 1'b1;
      hard_q    <= 1'b1;
    end else if (reset_src) begin
      rst_cnt_q <= 22'h000000;                                        // RULE17
      busy_q    <= 1'b1;
      long_q    <= long_q & busy_q | i_por;                           // RULE1
      hard_q    <= hard_q & busy_q | hard_src;
    end else if (seq_done) begin
      rst_cnt_q <= 22'h000000;
      busy_q    <= 1'b0;
      long_q    <= 1'b0;
      hard_q    <= 1'b0;
    end else if (busy_q) begin
      rst_cnt_q <= rst_cnt_q + 22'h000001;                            // RULE1
    end
  end

  // peripherals leave reset one phase ahead of the core
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_core_rst   <= 1'b1;
      o_periph_rst <= 1'b1;
    end else begin
      o_core_rst   <= reset_src | (busy_q & ~seq_done);               // RULE2
      o_periph_rst <= reset_src |
                      (busy_q & (rst_cnt_q < target - `PHASE_CYCLES - // RULE18
                                 22'h000001));
    end
  end

  // ***************************************************************
  // power mode state machine
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      sys_glue_pkg::ST_RESET: begin
        if (seq_done) begin
          state_d = sys_glue_pkg::ST_RUN;
        end
      end
      sys_glue_pkg::ST_RUN: begin
        if (i_debug_req) begin
          state_d = sys_glue_pkg::ST_DEBUG;
        end else if (i_stop_instr & ~i_stop_disable) begin            // RULE11
          state_d = sys_glue_pkg::ST_STOP;
        end else if (i_wait_instr & ~i_wait_disable) begin            // RULE11
          state_d = sys_glue_pkg::ST_WAIT;
        end
      end
      sys_glue_pkg::ST_WAIT: begin
        if (i_irq_wake | i_can_wake | i_debug_req) begin
          state_d = sys_glue_pkg::ST_RUN;
        end
      end
      sys_glue_pkg::ST_STOP: begin
        if (i_can_wake | i_irq_wake | i_debug_req) begin              // RULE10
          state_d = sys_glue_pkg::ST_RUN;
        end
      end
      sys_glue_pkg::ST_DEBUG: begin
        if (~i_debug_req) begin
          state_d = sys_glue_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = sys_glue_pkg::ST_RESET;
      end
    endcase
    if (reset_src) begin
      state_d = sys_glue_pkg::ST_RESET;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= sys_glue_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // clock gating per mode
  // ***************************************************************
  // gating follows the next state so enables change with the mode
  always_comb begin
    gate_d.core     = 1'b1;
    gate_d.mem      = 1'b1;
    gate_d.watchdog = 1'b1;
    gate_d.can      = 1'b1;
    gate_d.pwm_off  = 1'b0;
    gate_d.periph   = i_periph_clk_en;                                // RULE14
    case (state_d)
      sys_glue_pkg::ST_RESET: begin
        gate_d.periph = {PERIPHS{1'b1}};
      end
      sys_glue_pkg::ST_RUN: begin
        gate_d.core = 1'b1;                                           // RULE16
      end
      sys_glue_pkg::ST_WAIT: begin
        gate_d.core     = 1'b0;                                       // RULE5
        gate_d.mem      = 1'b0;                                       // RULE5
        gate_d.watchdog = ~i_wait_watchdog_stop;                      // RULE6
        gate_d.pwm_off  = i_wait_pwm_off;                             // RULE6
      end
      sys_glue_pkg::ST_STOP: begin
        gate_d.core     = 1'b0;                                       // RULE7
        gate_d.mem      = 1'b0;                                       // RULE7
        gate_d.periph   = {PERIPHS{1'b0}};                            // RULE7
        gate_d.watchdog = ~i_stop_watchdog_stop;                      // RULE8
        gate_d.can      = ~i_stop_can_stop;                           // RULE8
      end
      sys_glue_pkg::ST_DEBUG: begin
        gate_d.watchdog = 1'b0;                                       // RULE4
        gate_d.pwm_off  = i_debug_pwm_off;                            // RULE4
      end
      default: begin
        gate_d.core = 1'b1;
      end
    endcase
  end

  // pll is left alone here: software must shut it before stop
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_gate    <= '1;
      o_power_state <= sys_glue_pkg::ST_RESET;
    end else begin
      o_clk_gate    <= gate_d;
      o_power_state <= state_d;
    end
  end

  // ***************************************************************
  // core mode word
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_word_q <= `MODE_WORD_RESET;
    end else if (reset_src | busy_q) begin
      mode_word_q <= `MODE_WORD_RESET;                                // RULE15
      if (hard_src | hard_q) begin
        mode_word_q[`BOOT_LOW_BIT]  <= i_flash_secure;                // RULE15
        mode_word_q[`BOOT_HIGH_BIT] <= i_flash_secure;
      end else begin
        mode_word_q[`BOOT_LOW_BIT]  <= mode_word_q[`BOOT_LOW_BIT];    // RULE3
        mode_word_q[`BOOT_HIGH_BIT] <= mode_word_q[`BOOT_HIGH_BIT];   // RULE3
      end
    end else if (i_mode_word_wr) begin
      mode_word_q <= i_mode_word_wdata & `MODE_WORD_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_core_mode_word <= `MODE_WORD_RESET;
    end else begin
      o_core_mode_word <= mode_word_q;
    end
  end

  // ***************************************************************
  // scratch registers
  // ***************************************************************
  // only the power-on detector clears these; pin and soft resets do not
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        scratch_q[i] <= 16'h0000;
      end
    end else if (i_por) begin
      for (int i = 0; i < 4; i++) begin
        scratch_q[i] <= 16'h0000;                                     // RULE12
      end
    end else if (i_scratch_wr & ~o_core_rst) begin
      scratch_q[i_scratch_sel] <= i_scratch_wdata;                    // RULE12
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_scratch_rdata <= 16'h0000;
    end else begin
      o_scratch_rdata <= scratch_q[i_scratch_sel];
    end
  end

  // ***************************************************************
  // flash security
  // ***************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_jtag_flash_grant <= 1'b0;
    end else begin
      o_jtag_flash_grant <= i_jtag_flash_req & ~i_flash_secure;       // RULE13
    end
  end

endmodule

//--- rtl/sys_glue_regs.svh
// constants of the system glue unit: timing counts, mode word layout
// assumes inclusion by its bare name from the package and the design file
`ifndef SYS_GLUE_REGS_SVH
`define SYS_GLUE_REGS_SVH

// ***************************************************************
// reset stretch timing
// ***************************************************************
`define PHASE_CYCLES      22'h000020
`define PHASE_COUNT       22'h000003
`define POR_CYCLES        2097152

// ***************************************************************
// core mode word layout
// ***************************************************************
`define MODE_WORD_RESET   16'h0000
`define MODE_WORD_MASK    16'h81fb
`define BOOT_LOW_BIT      0
`define BOOT_HIGH_BIT     1
`define EXT_SPACE_BIT     3

`define PERIPH_COUNT      16

`endif

//--- rtl/sys_glue_pkg.sv
// types shared by the system glue unit and its bench
// assumes sys_glue_regs.svh sits beside it
`include "sys_glue_regs.svh"

package sys_glue_pkg;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_RUN   = 5'h02,
    ST_WAIT  = 5'h04,
    ST_STOP  = 5'h08,
    ST_DEBUG = 5'h10
  } power_state_t;

  typedef struct packed {
    logic                      core;
    logic                      mem;
    logic                      watchdog;
    logic                      can;
    logic                      pwm_off;
    logic [`PERIPH_COUNT-1:0]  periph;
  } clk_gate_t;

endpackage

//--- testbench/sys_glue_chk.sv
// checker for the system glue unit, bound from the bench top file
// assumes only the glue unit's ports, one clock domain
`timescale 1ns/1ns
module sys_glue_chk (
  input wire logic                       i_ref_clk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_por,
  input wire logic                       i_reset_pin_n,
  input wire logic                       i_watchdog_reset,
  input wire logic                       i_sw_reset,
  input wire logic                       i_flash_secure,
  input wire logic                       i_wait_instr,
  input wire logic                       i_stop_instr,
  input wire logic                       i_wait_disable,
  input wire logic                       i_debug_req,
  input wire logic                       i_debug_pwm_off,
  input wire logic                       i_wait_watchdog_stop,
  input wire logic                       i_wait_pwm_off,
  input wire logic                       i_stop_watchdog_stop,
  input wire logic                       i_stop_can_stop,
  input wire logic                       i_can_wake,
  input wire logic                       i_irq_wake,
  input wire logic                       i_jtag_flash_req,
  input wire logic                       o_core_rst,
  input wire logic                       o_periph_rst,
  input wire sys_glue_pkg::clk_gate_t    o_clk_gate,
  input wire sys_glue_pkg::power_state_t o_power_state,
  input wire logic [15:0]                o_core_mode_word,
  input wire logic                       o_jtag_flash_grant
);
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_src_resets_all: assert property ((i_por || !i_reset_pin_n ||
    i_watchdog_reset || i_sw_reset) |=> o_core_rst && o_periph_rst)
    else $error("reset source did not reset core and peripherals");
  a_phase_order: assert property ($fell(o_core_rst) |->
    !$past(o_periph_rst, 32) && $past(o_periph_rst, 33))
    else $error("core release not 32 clocks after peripherals");
  a_wait_clocks: assert property (o_power_state == sys_glue_pkg::ST_WAIT
    |-> !o_clk_gate.core && !o_clk_gate.mem &&
    o_clk_gate.watchdog == !$past(i_wait_watchdog_stop) &&
    o_clk_gate.pwm_off == $past(i_wait_pwm_off))
    else $error("wait mode clock gates wrong");
  a_stop_clocks: assert property (o_power_state == sys_glue_pkg::ST_STOP
    |-> !o_clk_gate.core && !o_clk_gate.mem && o_clk_gate.periph == '0 &&
    o_clk_gate.can == !$past(i_stop_can_stop) &&
    o_clk_gate.watchdog == !$past(i_stop_watchdog_stop))
    else $error("stop mode clock gates wrong");
  a_debug_gates: assert property (o_power_state == sys_glue_pkg::ST_DEBUG
    |-> !o_clk_gate.watchdog && o_clk_gate.pwm_off == $past(i_debug_pwm_off))
    else $error("debug mode watchdog or pwm gate wrong");
  a_stop_wakes: assert property (o_power_state == sys_glue_pkg::ST_STOP &&
    (i_can_wake || i_irq_wake) && !i_debug_req
    |=> o_power_state == sys_glue_pkg::ST_RUN)
    else $error("wake activity did not leave stop");
  a_wait_ignored: assert property (o_power_state == sys_glue_pkg::ST_RUN &&
    i_wait_instr && i_wait_disable && !i_stop_instr && !i_debug_req
    |=> o_power_state != sys_glue_pkg::ST_WAIT)
    else $error("disabled wait instruction entered wait");
  a_run_clocks: assert property (o_power_state == sys_glue_pkg::ST_RUN
    |-> o_clk_gate.core && o_clk_gate.mem)
    else $error("run mode without core or memory clock");
  a_flash_guard: assert property (!$past(i_sys_rst) |->
    o_jtag_flash_grant == $past(i_jtag_flash_req && !i_flash_secure))
    else $error("flash grant does not follow request and security");
  a_mode_zeros: assert property ((o_core_mode_word & 16'h7e04) == 16'h0000)
    else $error("unimplemented mode word bit set");
endmodule

//--- testbench/core_partner_model.sv
// behavioural core and reset pin driver facing the glue unit
// assumes requests from the bench, one clock
`timescale 1ns/1ns
module core_partner_model (
  input wire logic i_ref_clk,
  input wire logic i_core_rst,
  input wire logic i_req_wait,
  input wire logic i_req_stop,
  input wire logic i_req_pin,
  output logic     o_wait_instr = 1'b0,
  output logic     o_stop_instr = 1'b0,
  output logic     o_reset_pin_n = 1'b1
);
  // ***************************************************************
  // instruction and pin drive
  // ***************************************************************
  // a core held in reset executes nothing
  always @(posedge i_ref_clk) begin
    o_wait_instr <= i_req_wait && !i_core_rst;
    o_stop_instr <= i_req_stop && !i_core_rst;
    o_reset_pin_n <= !i_req_pin;
  end
  // pll is software's duty: never left to the glue unit
endmodule

//--- testbench/test_system_reset_power_mode_control.sv
// self-checking bench for the system glue unit
// assumes the package, design, checker and core model compiled first
`timescale 1ns/1ns
module test_system_reset_power_mode_control;
  // ***************************************************************
  // stimulus, design and partner
  // ***************************************************************
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_por = 1'b0;
  logic i_watchdog_reset = 1'b0, i_sw_reset = 1'b0, i_flash_secure = 1'b1;
  logic i_wait_disable = 1'b0, i_stop_disable = 1'b0, i_debug_req = 1'b0;
  logic i_debug_pwm_off = 1'b1, i_wait_watchdog_stop = 1'b1;
  logic i_wait_pwm_off = 1'b1, i_stop_watchdog_stop = 1'b0;
  logic i_stop_can_stop = 1'b1, i_can_wake = 1'b0, i_irq_wake = 1'b0;
  logic i_mode_word_wr = 1'b0, i_scratch_wr = 1'b0, i_jtag_flash_req = 1'b0;
  logic [1:0]  i_scratch_sel = 2'h2;
  logic [15:0] i_mode_word_wdata = 16'h0000, i_scratch_wdata = 16'h5a5a;
  logic [15:0] i_periph_clk_en = 16'hffff, o_core_mode_word, o_scratch_rdata;
  logic i_wait_instr, i_stop_instr, i_reset_pin_n, o_core_rst, o_periph_rst;
  logic o_jtag_flash_grant, req_wait = 1'b0, req_stop = 1'b0, req_pin = 1'b0;
  sys_glue_pkg::clk_gate_t    o_clk_gate;
  sys_glue_pkg::power_state_t o_power_state;
  int   bad_count = 0, check_count = 0, p, c;
  logic [3:0] rows [5] = '{4'b1000, 4'b0100, 4'b1010, 4'b0101, 4'b1100};
  logic [4:0] exp_st [5] = '{5'h04, 5'h08, 5'h02, 5'h02, 5'h08};

  system_reset_power_mode_control #(.POR_CYCLES(200))
    system_reset_power_mode_control_i (.i_ref_clk, .i_sys_rst, .i_por,
    .i_reset_pin_n, .i_watchdog_reset, .i_sw_reset, .i_flash_secure,
    .i_wait_instr, .i_stop_instr, .i_wait_disable, .i_stop_disable,
    .i_debug_req, .i_debug_pwm_off, .i_wait_watchdog_stop, .i_wait_pwm_off,
    .i_stop_watchdog_stop, .i_stop_can_stop, .i_can_wake, .i_irq_wake,
    .i_periph_clk_en, .i_mode_word_wr, .i_mode_word_wdata, .i_scratch_wr,
    .i_scratch_sel, .i_scratch_wdata, .i_jtag_flash_req, .o_core_rst,
    .o_periph_rst, .o_clk_gate, .o_power_state, .o_core_mode_word,
    .o_scratch_rdata, .o_jtag_flash_grant);
  core_partner_model core_partner_model_i (.i_ref_clk, .i_core_rst(o_core_rst),
    .i_req_wait(req_wait), .i_req_stop(req_stop), .i_req_pin(req_pin),
    .o_wait_instr(i_wait_instr), .o_stop_instr(i_stop_instr),
    .o_reset_pin_n(i_reset_pin_n));

  always #20 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // edges from the source edge until each reset falls, bounded
  task automatic rel_time(output int pt, output int ct);
    pt = 0;
    ct = 0;
    for (int n = 1; n < 400 && ct == 0; n++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_periph_rst === 1'b0 && pt == 0) pt = n;
      if (o_core_rst === 1'b0) ct = n;
    end
    if (ct == 0) begin
      bad_count++;
      end_of_test;
    end
  endtask
  task automatic wr_mode(input logic [15:0] d);
    tick(1);
    i_mode_word_wr <= 1'b1;
    i_mode_word_wdata <= d;
    tick(1);
    i_mode_word_wr <= 1'b0;
    tick(2);
    #1;
  endtask

  initial begin
    tick(12);
    i_sys_rst <= 1'b0;
    rel_time(p, c);
    chk(16'(c), 16'd200);
    for (int r = 0; r < 5; r++) begin
      tick(1);
      {i_wait_disable, i_stop_disable} <= rows[r][1:0];
      {req_wait, req_stop} <= rows[r][3:2];
      tick(1);
      {req_wait, req_stop} <= 2'b00;
      tick(1);
      #1 chk(16'(o_power_state), 16'(exp_st[r]));
      tick(1);
      i_irq_wake <= 1'b1;
      tick(1);
      i_irq_wake <= 1'b0;
      #1 chk(16'(o_power_state), 16'h0002);
    end
    // awkward cases
    tick(1);
    {i_wait_disable, i_stop_disable, req_stop} <= 3'b001;
    tick(1);
    req_stop <= 1'b0;
    tick(3);
    #1 chk(16'(o_power_state), 16'h0008);
    i_can_wake <= 1'b1;
    tick(1);
    i_can_wake <= 1'b0;
    #1 chk(16'(o_power_state), 16'h0002);
    req_pin <= 1'b1;
    tick(2);
    req_pin <= 1'b0;
    rel_time(p, c);
    chk(o_core_mode_word, 16'h0003);
    wr_mode(16'h0000);
    chk(o_core_mode_word, 16'h0000);
    wr_mode(16'hffff);
    chk(o_core_mode_word, 16'h81fb);
    wr_mode(16'h0001);
    i_scratch_wr <= 1'b1;
    tick(1);
    i_scratch_wr <= 1'b0;
    i_watchdog_reset <= 1'b1;
    tick(1);
    i_watchdog_reset <= 1'b0;
    tick(40);
    i_sw_reset <= 1'b1;
    tick(1);
    i_sw_reset <= 1'b0;
    rel_time(p, c);
    chk(16'(p), 16'd64);
    chk(16'(c), 16'd96);
    tick(2);
    #1 chk(o_core_mode_word, 16'h0001);
    chk(o_scratch_rdata, 16'h5a5a);
    i_debug_req <= 1'b1;
    i_periph_clk_en <= 16'h00a5;
    i_jtag_flash_req <= 1'b1;
    tick(2);
    #1 chk(16'(o_power_state), 16'h0010);
    chk(16'(o_jtag_flash_grant), 16'h0000);
    i_debug_req <= 1'b0;
    i_flash_secure <= 1'b0;
    tick(2);
    #1 chk(o_clk_gate.periph, 16'h00a5);
    chk(16'(o_jtag_flash_grant), 16'h0001);
    i_por <= 1'b1;
    tick(1);
    i_por <= 1'b0;
    rel_time(p, c);
    chk(16'(c), 16'd200);
    tick(2);
    #1 chk(o_scratch_rdata, 16'h0000);
    end_of_test;
  end
endmodule

bind system_reset_power_mode_control sys_glue_chk sys_glue_chk_i (.i_ref_clk,
  .i_sys_rst, .i_por, .i_reset_pin_n, .i_watchdog_reset, .i_sw_reset,
  .i_flash_secure, .i_wait_instr, .i_stop_instr, .i_wait_disable,
  .i_debug_req, .i_debug_pwm_off, .i_wait_watchdog_stop, .i_wait_pwm_off,
  .i_stop_watchdog_stop, .i_stop_can_stop, .i_can_wake, .i_irq_wake,
  .i_jtag_flash_req, .o_core_rst, .o_periph_rst, .o_clk_gate,
  .o_power_state, .o_core_mode_word, .o_jtag_flash_grant);
